// File: dv/fcz_card_model.sv
// Behavioural flash card: zone command registers, array and identifier
`timescale 1ns/10ps
module fcz_card_model #(
  parameter int         ADDR_W = 20,
  parameter logic [7:0] MFR    = 8'h5A,  // Arbitrary identifier value
  parameter logic [7:0] DEV    = 8'h3C   // Arbitrary identifier value
) (
  input  wire logic              i_supply,
  input  wire logic              i_sel_lo_n,
  input  wire logic              i_sel_hi_n,
  input  wire logic              i_gate_n,
  input  wire logic              i_strobe_n,
  input  wire logic              i_lane,
  input  wire logic [ADDR_W-1:1] i_addr,
  input  wire logic [15:0]       i_dq,
  output logic      [15:0]       o_dq
);
  // ************************
  // Zone state and array
  // ************************
  localparam int NZ = 1 << (ADDR_W - 17);
  localparam int RD = 0, ID = 1, ES = 2, PS = 3, CK = 4, R1 = 5;
  int          mode [NZ] = '{default: 0};
  int          chk  [NZ];
  logic [15:0] mem  [int];
  int          loc;
  logic        wl;
  logic [15:0] last = 16'h0000;

  function automatic logic [15:0] rd(int a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction

  // Low supply drops every zone back to array reads
  always @(negedge i_supply) foreach (mode[k]) mode[k] = RD;

  // Address taken as the strobe falls
  always @(negedge i_strobe_n) begin
    loc = int'(i_addr);
    wl = i_lane;
  end

  // Data and command taken as the strobe rises; only a gated-off cycle writes
  always @(posedge i_strobe_n) begin : wr
    int          z;
    logic [15:0] v;
    logic [15:0] m;
    logic [7:0]  c;
    z = loc >> 16;
    m = i_sel_lo_n ? 16'hFF00 : (!i_sel_hi_n ? 16'hFFFF : (wl ? 16'hFF00 : 16'h00FF));
    v = (!i_sel_lo_n && i_sel_hi_n) ? {2{i_dq[7:0]}} : i_dq;
    c = i_sel_lo_n ? i_dq[15:8] : i_dq[7:0];
    if (!i_supply) begin
      mode[z] = RD;
    end else if (i_gate_n && !(i_sel_lo_n && i_sel_hi_n)) begin
      if (mode[z] == PS) begin
        // Flash programming only clears bits, so FF leaves contents alone
        mem[loc] = rd(loc) & (v | ~m);
        chk[z] = loc;
        mode[z] = RD;
      end else if (mode[z] == ES && c == 8'h20) begin
        foreach (mem[k]) if ((k >> 16) == z) mem[k] = 16'hFFFF;
        mode[z] = RD;
      end else if (mode[z] == R1 && c == 8'hFF) begin
        mode[z] = RD;
      end else begin
        case (c)
          8'h90:   mode[z] = ID;
          8'h20:   mode[z] = ES;
          8'hA0:   begin
            mode[z] = CK;
            chk[z] = loc;
          end
          8'h40:   mode[z] = PS;
          8'hC0:   mode[z] = CK;
          8'hFF:   mode[z] = R1;
          default: mode[z] = RD;
        endcase
      end
    end
  end

  // Read lanes; released bytes show a changing pattern, never the old value
  always @(i_gate_n or i_sel_lo_n or i_sel_hi_n or i_addr or i_lane) begin : rp
    int          a;
    logic [15:0] w;
    a = int'(i_addr);
    if (mode[a >> 16] == ID) begin
      w = {2{i_addr[16:1] == 0 ? MFR : (i_addr[16:1] == 1 ? DEV : 8'h00)}};
    end else if (mode[a >> 16] == CK) begin
      w = rd(chk[a >> 16]);
    end else begin
      w = rd(a);
    end
    o_dq = ~last;
    if (!i_gate_n && !i_sel_lo_n) o_dq[7:0] = (i_sel_hi_n && i_lane) ? w[15:8] : w[7:0];
    if (!i_gate_n && !i_sel_hi_n) o_dq[15:8] = w[15:8];
    last = o_dq;
  end
endmodule

// File: dv/fcz_host_tb.sv
// Self-checking bench of the flash card zone host controller
`timescale 1ns/10ps
module fcz_host_tb;
  import fcz_pkg::*;
  localparam logic [7:0] MFR = 8'h5A;  // Arbitrary identifier value
  localparam logic [7:0] DEV = 8'h3C;  // Arbitrary identifier value
  logic        clk = 1'b0, rst = 1'b1, en = 1'b1, req = 1'b0, pen = 1'b0;
  fcz_op_t     op = OP_READ;
  fcz_lane_t   lm = LANE_WORD;
  logic [19:0] addr = 20'h0_0000;
  logic [15:0] wdat = 16'h0000;
  logic        rdy, done, err, sup, slo, shi, gate, strb, lane, oelo, oehi, e_got;
  logic [15:0] rdata, dqo, card_dq, bus;
  logic [19:1] oaddr;
  int          failures = 0, n_compared = 0, cycles = 0;
  logic [31:0] seed = 32'd94;
  logic [15:0] ref_mem [int];

  // Each byte of the data bus is driven by the host or else by the card
  assign bus = {oehi ? dqo[15:8] : card_dq[15:8], oelo ? dqo[7:0] : card_dq[7:0]};

  fcz_host #(.ADDR_W(20), .ERASE_CYC(20)) fcz_host_inst (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_clk_en(en), .i_req(req), .i_op(op), .i_lane_mode(lm), .i_addr(addr), .i_wdata(wdat),
    .i_prog_enable(pen), .o_ready(rdy), .o_rdata(rdata), .o_done(done), .o_err(err),
    .o_program_supply_high(sup), .o_card_select_low_byte_n(slo),
    .o_card_select_high_byte_n(shi), .o_output_gate_n(gate), .o_write_strobe_n(strb),
    .o_byte_lane_select(lane), .o_addr(oaddr), .o_dq_o(dqo), .o_dq_oe_lo(oelo),
    .o_dq_oe_hi(oehi), .i_dq_i(bus));
  fcz_card_model #(.ADDR_W(20), .MFR(MFR), .DEV(DEV)) fcz_card_model_inst (.i_supply(sup),
    .i_sel_lo_n(slo), .i_sel_hi_n(shi), .i_gate_n(gate), .i_strobe_n(strb), .i_lane(lane),
    .i_addr(oaddr), .i_dq(bus), .o_dq(card_dq));

  // ************************
  // Helpers
  // ************************
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [15:0] rw(int a);
    return ref_mem.exists(a) ? ref_mem[a] : 16'hFFFF;
  endfunction
  function logic [15:0] exp_rd(fcz_lane_t m, logic [19:0] a);
    logic [15:0] w;
    w = rw(int'(a >> 1));
    if (m == LANE_WORD) return w;
    return {8'h00, (m == LANE_HIGH || a[0]) ? w[15:8] : w[7:0]};
  endfunction
  // Reference programming only clears bits within the written lane
  task ref_prog(fcz_lane_t m, logic [19:0] a, logic [15:0] d);
    logic [15:0] mk;
    mk = (m == LANE_WORD) ? 16'hFFFF : ((m == LANE_HIGH || a[0]) ? 16'hFF00 : 16'h00FF);
    ref_mem[int'(a >> 1)] = rw(int'(a >> 1)) & ((m == LANE_WORD ? d : {2{d[7:0]}}) | ~mk);
  endtask
  task cmp16(logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask
  task cmp1(logic got, logic exp);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask
  task finish_test();
    $display("failures=%0d n_compared=%0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task issue(fcz_op_t o, fcz_lane_t m, logic [19:0] a, logic [15:0] d);
    op = o;
    lm = m;
    addr = a;
    wdat = d;
    req = 1'b1;
  endtask
  // Request is taken at the next edge; one idle cycle follows the done pulse
  task await();
    int n;
    n = 0;
    @(posedge clk);
    @(negedge clk);
    req = 1'b0;
    while (done !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    // An operation that never finishes counts as a mismatch
    if (n == 2000) failures++;
    e_got = err;
    @(negedge clk);
  endtask
  task run(fcz_op_t o, fcz_lane_t m, logic [19:0] a, logic [15:0] d);
    issue(o, m, a, d);
    await();
  endtask

  // Clock and hang guard
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      finish_test();
    end
  end

  // Every write strobe falls with a select active and the gate off
  always @(negedge strb) begin
    if (rst === 1'b0) begin
      cmp1(slo & shi, 1'b0);
      cmp1(gate, 1'b1);
    end
  end

  // ************************
  // Main sequence
  // ************************
  initial begin
    logic [31:0] r;
    fcz_lane_t   m;
    fcz_lane_t   m2;
    logic [19:0] a;
    logic [19:0] b;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    for (int i = 1; i < 8; i++) begin
      run(fcz_op_t'(i), LANE_WORD, 20'h0_0000, 16'h0000);
      cmp1(e_got, 1'b1);
      cmp1(rdy, 1'b1);
    end
    run(OP_READ, LANE_WORD, 20'h0_0000, 16'h0000);
    cmp16(rdata, 16'hFFFF);
    pen = 1'b1;
    repeat (2) @(negedge clk);
    cmp1(sup, 1'b1);
    // Random programs over few words so lanes overlap
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      m = fcz_lane_t'(r[1:0] % 3);
      m2 = fcz_lane_t'(r[10:9] % 3);
      a = {r[4:2], 13'h0000, r[8:5]};
      run(OP_PROGRAM, m, a, r[31:16]);
      cmp1(e_got, 1'b0);
      ref_prog(m, a, r[31:16]);
      cmp16(rdata, exp_rd(m, a));
      run(OP_READ, m2, a, 16'h0000);
      cmp16(rdata, exp_rd(m2, a));
    end
    // Erase one zone; its neighbour keeps its data
    b = a ^ 20'h2_0000;
    run(OP_PROGRAM, LANE_WORD, b, 16'h0F0F);
    ref_prog(LANE_WORD, b, 16'h0F0F);
    run(OP_ERASE, LANE_WORD, a, 16'h0000);
    foreach (ref_mem[k]) if ((k >> 16) == int'(a >> 17)) ref_mem[k] = 16'hFFFF;
    cmp16(rdata, 16'hFFFF);
    run(OP_ERASE_CHECK, LANE_WORD, b, 16'h0000);
    cmp16(rdata, exp_rd(LANE_WORD, b));
    // Identifier persists until a new command
    run(OP_IDENT, LANE_WORD, 20'hA_0000, 16'h0000);
    cmp16(rdata, {MFR, MFR});
    run(OP_READ, LANE_BYTE, 20'hA_0002, 16'h0000);
    cmp16(rdata, {8'h00, DEV});
    run(OP_READ_ARRAY, LANE_WORD, 20'hA_0000, 16'h0000);
    run(OP_READ, LANE_WORD, 20'hA_0002, 16'h0000);
    cmp16(rdata, exp_rd(LANE_WORD, 20'hA_0002));
    // Reset acts on one zone; the card-wide reset visits all
    run(OP_IDENT, LANE_WORD, 20'h4_0000, 16'h0000);
    run(OP_IDENT, LANE_WORD, 20'hC_0000, 16'h0000);
    run(OP_RESET, LANE_WORD, 20'h4_0000, 16'h0000);
    run(OP_READ, LANE_WORD, 20'h4_0000, 16'h0000);
    cmp16(rdata, exp_rd(LANE_WORD, 20'h4_0000));
    run(OP_READ, LANE_WORD, 20'hC_0000, 16'h0000);
    cmp16(rdata, {MFR, MFR});
    run(OP_RESET_ALL, LANE_WORD, 20'h0_0000, 16'h0000);
    // Frozen enable holds the request back, then it runs
    en = 1'b0;
    issue(OP_READ, LANE_WORD, 20'hC_0000, 16'h0000);
    repeat (5) @(negedge clk);
    cmp1(gate, 1'b1);
    en = 1'b1;
    await();
    cmp16(rdata, exp_rd(LANE_WORD, 20'hC_0000));
    // Dropping the supply forces array reads
    run(OP_IDENT, LANE_WORD, 20'h2_0000, 16'h0000);
    pen = 1'b0;
    repeat (3) @(negedge clk);
    run(OP_READ, LANE_WORD, 20'h2_0000, 16'h0000);
    cmp16(rdata, exp_rd(LANE_WORD, 20'h2_0000));
    finish_test();
  end
endmodule

// File: rtl/fcz_host.sv
// Host controller that drives a flash card's zone command registers
`timescale 1ns/10ps
module fcz_host #(
  parameter int ADDR_W    = 20,
  parameter int ERASE_CYC = 250000
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_sys_rst,
  input  wire logic               i_clk_en,
  input  wire logic               i_req,
  input  wire fcz_pkg::fcz_op_t   i_op,
  input  wire fcz_pkg::fcz_lane_t i_lane_mode,
  input  wire logic [ADDR_W-1:0]  i_addr,
  input  wire logic [15:0]        i_wdata,
  input  wire logic               i_prog_enable,
  output logic                    o_ready,
  output logic [15:0]             o_rdata,
  output logic                    o_done,
  output logic                    o_err,
  output logic                    o_program_supply_high,
  output logic                    o_card_select_low_byte_n,
  output logic                    o_card_select_high_byte_n,
  output logic                    o_output_gate_n,
  output logic                    o_write_strobe_n,
  output logic                    o_byte_lane_select,
  output logic [ADDR_W-1:1]       o_addr,
  output logic [15:0]             o_dq_o,
  output logic                    o_dq_oe_lo,
  output logic                    o_dq_oe_hi,
  input  wire logic [15:0]        i_dq_i
);
  import fcz_pkg::*;

  localparam int ZONE_W = ADDR_W - ZONE_SHIFT;

  typedef struct packed {
    fcz_state_t         st;
    fcz_op_t            op;
    logic [2:0]         step;
    logic [CNT_W-1:0]   cnt;
    logic [ZONE_W-1:0]  zone;
    logic [ADDR_W-1:0]  addr;
    logic [15:0]        wdata;
    fcz_lane_t          lane;
    logic [15:0]        dq;
    logic               oe_lo;
    logic               oe_hi;
    logic               sel_lo_n;
    logic               sel_hi_n;
    logic               lane_bit;
    logic               gate_n;
    logic               strobe_n;
    logic [15:0]        rdata;
    logic               done;
    logic               err;
    logic               supply;
  } fcz_host_t;

  fcz_host_t r;
  fcz_host_t next_r;

  fcz_kind_t   kind;
  logic [7:0]  code;
  logic [15:0] pre_data;
  logic        l_sel_lo_n;
  logic        l_sel_hi_n;
  logic        l_lane;
  logic [15:0] l_dq;
  logic        l_oe_lo;
  logic        l_oe_hi;
  logic [15:0] l_rword;

  // ******************************************
  // Command sequences per operation
  // ******************************************
  // Each op is a short list of bus steps; one table keeps the order auditable
  always_comb begin
    kind = K_END;
    code = CMD_READ_ARRAY;
    unique case (r.op)
      OP_READ: begin
        if (r.step == 3'h0) kind = K_READ;   // RULE_07
      end
      OP_READ_ARRAY: begin
        if (r.step == 3'h0) kind = K_WR_CMD; // RULE_08 RULE_10
      end
      OP_IDENT: begin
        unique case (r.step)
          3'h0: begin
            kind = K_WR_CMD;                 // RULE_09
            code = CMD_IDENT;
          end
          3'h1: kind = K_READ;               // RULE_22
          default: kind = K_END;
        endcase
      end
      OP_ERASE, OP_ERASE_CHECK: begin
        unique case (r.op == OP_ERASE ? r.step : r.step + 3'h3)
          3'h0, 3'h1: begin
            kind = K_WR_CMD;                 // RULE_11
            code = CMD_ERASE;
          end
          3'h2: kind = K_DW_ERASE;           // RULE_12
          3'h3: begin
            kind = K_WR_CMD;                 // RULE_14
            code = CMD_ERASE_CHK;
          end
          3'h4: kind = K_READ;
          default: kind = K_END;
        endcase
      end
      OP_PROGRAM: begin
        unique case (r.step)
          3'h0: begin
            kind = K_WR_CMD;                 // RULE_15
            code = CMD_PROGRAM;
          end
          3'h1: kind = K_WR_DATA;
          3'h2: kind = K_DW_PROG;
          3'h3: begin
            kind = K_WR_CMD;                 // RULE_16
            code = CMD_PROG_CHK;
          end
          3'h4: kind = K_READ;
          default: kind = K_END;
        endcase
      end
      OP_RESET, OP_RESET_ALL: begin
        unique case (r.step)
          3'h0, 3'h1: begin
            kind = K_WR_CMD;                 // RULE_24
            code = CMD_RESET;
          end
          3'h2: kind = K_WR_CMD;             // RULE_18
          default: kind = K_END;
        endcase
      end
    endcase
    pre_data = (kind == K_WR_DATA) ? r.wdata : {code, code};
  end

  fcz_lane u_lane (
    .i_mode     (r.lane),
    .i_addr0    (r.addr[0]),
    .i_wdata    (pre_data),
    .i_dq       (i_dq_i),
    .o_sel_lo_n (l_sel_lo_n),
    .o_sel_hi_n (l_sel_hi_n),
    .o_lane     (l_lane),
    .o_dq       (l_dq),
    .o_oe_lo    (l_oe_lo),
    .o_oe_hi    (l_oe_hi),
    .o_rword    (l_rword)
  );

  // ******************************************
  // Sequencer
  // ******************************************
  always_comb begin
    next_r        = r;
    next_r.done   = 1'b0;
    next_r.err    = 1'b0;
    next_r.supply = i_prog_enable;
    unique case (r.st)
      S_IDLE: begin
        if (i_req) begin
          // Alteration with the supply low would silently fail; refuse it
          if (i_op != OP_READ && !r.supply) begin
            next_r.err  = 1'b1;                // RULE_01
            next_r.done = 1'b1;
          end else begin
            next_r.st    = S_NEXT;
            next_r.op    = i_op;
            next_r.step  = 3'h0;
            next_r.zone  = '0;
            next_r.addr  = (i_op == OP_RESET_ALL) ? '0 : i_addr;  // RULE_02
            next_r.wdata = i_wdata;
            next_r.lane  = i_lane_mode;
          end
        end
      end
      S_NEXT: begin
        next_r.sel_lo_n = l_sel_lo_n;
        next_r.sel_hi_n = l_sel_hi_n;
        next_r.lane_bit = l_lane;
        unique case (kind)
          K_WR_CMD, K_WR_DATA: begin
            next_r.dq    = l_dq;
            next_r.oe_lo = l_oe_lo;
            next_r.oe_hi = l_oe_hi;
            next_r.st    = S_SETUP;
          end
          K_READ: begin
            next_r.gate_n = 1'b0;
            next_r.cnt    = CNT_W'(READ_CYC - 1);
            next_r.st     = S_READ;
          end
          K_DW_ERASE, K_DW_PROG: begin
            next_r.sel_lo_n = 1'b1;
            next_r.sel_hi_n = 1'b1;
            next_r.cnt = (kind == K_DW_ERASE) ? CNT_W'(ERASE_CYC - 1)  // RULE_13
                                              : CNT_W'(PROG_CYC - 1);
            next_r.st  = S_DWELL;
          end
          K_END: begin
            next_r.sel_lo_n = 1'b1;
            next_r.sel_hi_n = 1'b1;
            // Reset reaches one zone only, so walk all of them in turn
            if (r.op == OP_RESET_ALL && r.zone != {ZONE_W{1'b1}}) begin
              next_r.zone = r.zone + 1'b1;     // RULE_19
              next_r.addr = ADDR_W'({r.zone + 1'b1, {ZONE_SHIFT{1'b0}}});  // RULE_20
              next_r.step = 3'h0;
            end else begin
              next_r.done = 1'b1;
              next_r.st   = S_IDLE;
            end
          end
          default: next_r.st = S_IDLE;
        endcase
      end
      S_SETUP: begin
        next_r.strobe_n = 1'b0;                // RULE_17
        next_r.cnt      = CNT_W'(STROBE_CYC - 1);
        next_r.st       = S_STROBE;
      end
      S_STROBE: begin
        if (r.cnt == '0) begin
          next_r.strobe_n = 1'b1;
          next_r.st       = S_HOLD;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      S_HOLD: begin
        // One cycle of hold after the rising edge keeps address and data valid
        next_r.sel_lo_n = 1'b1;
        next_r.sel_hi_n = 1'b1;
        next_r.oe_lo    = 1'b0;
        next_r.oe_hi    = 1'b0;
        next_r.step     = r.step + 1'b1;
        next_r.st       = S_NEXT;
      end
      S_READ: begin
        if (r.cnt == '0) begin
          next_r.rdata    = l_rword;
          next_r.gate_n   = 1'b1;
          next_r.sel_lo_n = 1'b1;
          next_r.sel_hi_n = 1'b1;
          next_r.step     = r.step + 1'b1;
          next_r.st       = S_NEXT;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      S_DWELL: begin
        if (r.cnt == '0) begin
          next_r.step = r.step + 1'b1;
          next_r.st   = S_NEXT;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      default: next_r.st = S_IDLE;
    endcase
  end

  // State register; the clock enable freezes everything except the synchronous reset
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      r          <= '0;
      r.st       <= S_IDLE;
      r.sel_lo_n <= 1'b1;
      r.sel_hi_n <= 1'b1;
      r.gate_n   <= 1'b1;
      r.strobe_n <= 1'b1;
    end else if (i_clk_en) begin
      r <= next_r;
    end
  end

  // ******************************************
  // Outputs
  // ******************************************
  assign o_ready                   = (r.st == S_IDLE);
  assign o_rdata                   = r.rdata;
  assign o_done                    = r.done;
  assign o_err                     = r.err;
  assign o_program_supply_high     = r.supply;
  assign o_card_select_low_byte_n  = r.sel_lo_n;
  assign o_card_select_high_byte_n = r.sel_hi_n;
  assign o_output_gate_n           = r.gate_n;
  assign o_write_strobe_n          = r.strobe_n;
  assign o_byte_lane_select        = r.lane_bit;
  assign o_addr                    = r.addr[ADDR_W-1:1];
  assign o_dq_o                    = r.dq;
  assign o_dq_oe_lo                = r.oe_lo;
  assign o_dq_oe_hi                = r.oe_hi;

  // ******************************************
  // Assertions
  // ******************************************
  property p_strobe_select;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      !o_write_strobe_n |-> (!o_card_select_low_byte_n || !o_card_select_high_byte_n);
  endproperty
  a_strobe_select: assert property (p_strobe_select) // RULE_23
    else $error("strobe low without a card select");

  property p_write_gate;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      !o_write_strobe_n |-> (o_output_gate_n && (o_dq_oe_lo || o_dq_oe_hi));
  endproperty
  a_write_gate: assert property (p_write_gate) // RULE_25
    else $error("write cycle without gate high and data driven");

  property p_supply_on_write;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      $fell(o_write_strobe_n) |-> $past(o_program_supply_high, 2);
  endproperty
  a_supply_on_write: assert property (p_supply_on_write) // RULE_01
    else $error("command written while program supply low");

  property p_strobe_width;
    @(posedge i_ref_clk) disable iff (i_sys_rst || !i_clk_en)
      $fell(o_write_strobe_n) |-> !o_write_strobe_n [*3] ##1 o_write_strobe_n;
  endproperty
  a_strobe_width: assert property (p_strobe_width) // RULE_17
    else $error("write strobe pulse width wrong");

  property p_addr_stable;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (!o_write_strobe_n || $rose(o_write_strobe_n)) |-> $stable(o_addr) && $stable(o_dq_o);
  endproperty
  a_addr_stable: assert property (p_addr_stable) // RULE_02
    else $error("address or data moved during a write pulse");

  property p_high_only;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (o_card_select_low_byte_n && !o_card_select_high_byte_n) |-> !o_dq_oe_lo;
  endproperty
  a_high_only: assert property (p_high_only) // RULE_05
    else $error("lower lines driven in high byte access");

  property p_byte_lane;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      (!o_card_select_low_byte_n && o_card_select_high_byte_n) |->
        (o_byte_lane_select == r.addr[0]) && !o_dq_oe_hi;
  endproperty
  a_byte_lane: assert property (p_byte_lane) // RULE_03
    else $error("byte lane select does not follow address in byte access");

  property p_no_contention;
    @(posedge i_ref_clk) disable iff (i_sys_rst)
      !o_output_gate_n |-> !o_dq_oe_lo && !o_dq_oe_hi && o_write_strobe_n;
  endproperty
  a_no_contention: assert property (p_no_contention) // RULE_06
    else $error("host drives data while card output gate open");

  property p_done_pulse;
    @(posedge i_ref_clk) disable iff (i_sys_rst || !i_clk_en)
      o_done |=> !o_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) // RULE_07
    else $error("done longer than one cycle");

endmodule

// File: rtl/fcz_lane.sv
// Lane mapper: card selects, byte lane and data placement per access width
`timescale 1ns/10ps
module fcz_lane (
  input  wire fcz_pkg::fcz_lane_t i_mode,
  input  wire logic               i_addr0,
  input  wire logic [15:0]        i_wdata,
  input  wire logic [15:0]        i_dq,
  output logic                    o_sel_lo_n,
  output logic                    o_sel_hi_n,
  output logic                    o_lane,
  output logic [15:0]             o_dq,
  output logic                    o_oe_lo,
  output logic                    o_oe_hi,
  output logic [15:0]             o_rword
);
  import fcz_pkg::*;

  // Width decode; same lanes for reads and writes
  always_comb begin
    o_sel_lo_n = 1'b1;
    o_sel_hi_n = 1'b1;
    o_lane     = 1'b0;
    o_dq       = i_wdata;
    o_oe_lo    = 1'b0;
    o_oe_hi    = 1'b0;
    o_rword    = i_dq;
    unique case (i_mode)
      LANE_BYTE: begin
        o_sel_lo_n = 1'b0;
        o_lane     = i_addr0;                // RULE_03
        o_dq       = {BYTE_ZERO, i_wdata[7:0]}; // RULE_04
        o_oe_lo    = 1'b1;
        o_rword    = {BYTE_ZERO, i_dq[7:0]};
      end
      LANE_HIGH: begin
        o_sel_hi_n = 1'b0;                   // RULE_05
        o_dq       = {i_wdata[7:0], BYTE_ZERO};
        o_oe_hi    = 1'b1;
        o_rword    = {BYTE_ZERO, i_dq[15:8]};
      end
      LANE_WORD: begin
        o_sel_lo_n = 1'b0;                   // RULE_06
        o_sel_hi_n = 1'b0;
        o_oe_lo    = 1'b1;
        o_oe_hi    = 1'b1;
      end
      default: begin
        o_sel_lo_n = 1'b1;
      end
    endcase
  end

endmodule

// File: rtl/fcz_pkg.sv
// Constants, codes and types of the flash card zone host controller
// Behaviour
// RULE_01: Low program supply forces read code 00H
// RULE_02: Host gives valid address every bus cycle
// RULE_03: Low select, lane low: low byte
// RULE_04: Low select, lane high: high byte low lines
// RULE_05: High select only: upper lines, lower tri-state
// RULE_06: Both selects: full word, lane ignored
// RULE_07: Low supply allows reads, refuses alteration
// RULE_08: Code 00H selects array reads for zone
// RULE_09: Code 90H then reads return identifier codes
// RULE_10: Host leaves identifier mode by new command
// RULE_11: Two 20H writes arm then start erase
// RULE_12: Erase runs until next strobe rising edge
// RULE_13: Erase only with program supply high
// RULE_14: A0H write then read gives erase check
// RULE_15: 40H write then value write programs
// RULE_16: C0H write then read gives program check
// RULE_17: Address on strobe fall, data on rise
// RULE_18: Two FFH writes then next command
// RULE_19: Whole card reset needs every zone
// RULE_20: Erase acts on one 128 kByte zone
// RULE_21: Powered high supply starts in read mode
// RULE_22: High supply reads give array or identifier
// RULE_23: Strobe low only while select low
// RULE_24: Two FFH writes abort pending set-up
// RULE_25: Strobe low with gate high is write
package fcz_pkg;

  // ******************************************
  // Command codes, one byte, replicated in word mode
  // ******************************************
  localparam logic [7:0] CMD_READ_ARRAY = 8'h00;
  localparam logic [7:0] CMD_IDENT      = 8'h90;
  localparam logic [7:0] CMD_ERASE      = 8'h20;
  localparam logic [7:0] CMD_ERASE_CHK  = 8'hA0;
  localparam logic [7:0] CMD_PROGRAM    = 8'h40;
  localparam logic [7:0] CMD_PROG_CHK   = 8'hC0;
  localparam logic [7:0] CMD_RESET      = 8'hFF;
  localparam logic [7:0] BYTE_ZERO      = 8'h00;

  // ******************************************
  // Geometry
  // ******************************************
  localparam int ZONE_SHIFT = 17;   // 128 kByte zone
  localparam int DATA_W     = 16;

  // ******************************************
  // Timing, in ns, and derived clock counts at 25 MHz
  // ******************************************
  localparam int CLK_PERIOD_NS   = 40;
  localparam int T_STROBE_LOW_NS = 100;
  localparam int T_READ_ACC_NS   = 250;
  localparam int T_PROGRAM_NS    = 10000;
  localparam int STROBE_CYC = (T_STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC   = (T_READ_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYC   = (T_PROGRAM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W      = 18;

  // ******************************************
  // Types
  // ******************************************
  typedef enum logic [2:0] {
    OP_READ        = 3'b000,
    OP_READ_ARRAY  = 3'b001,
    OP_IDENT       = 3'b010,
    OP_ERASE       = 3'b011,
    OP_ERASE_CHECK = 3'b100,
    OP_PROGRAM     = 3'b101,
    OP_RESET       = 3'b110,
    OP_RESET_ALL   = 3'b111
  } fcz_op_t;

  typedef enum logic [1:0] {
    LANE_BYTE = 2'b00,
    LANE_HIGH = 2'b01,
    LANE_WORD = 2'b10
  } fcz_lane_t;

  typedef enum logic [2:0] {
    K_WR_CMD   = 3'b000,
    K_WR_DATA  = 3'b001,
    K_READ     = 3'b010,
    K_DW_ERASE = 3'b011,
    K_DW_PROG  = 3'b100,
    K_END      = 3'b101
  } fcz_kind_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_NEXT   = 3'b001,
    S_SETUP  = 3'b010,
    S_STROBE = 3'b011,
    S_HOLD   = 3'b100,
    S_READ   = 3'b101,
    S_DWELL  = 3'b110
  } fcz_state_t;

endpackage
